// *** gsf_pkg.sv ***
// Purpose: shared constants and types of the gyro sample buffer
// Assumes: byte-wide register port, one sample set is three 16-bit channels
// Notes:   offsets are byte addresses of the register port
package gsf_pkg;
  localparam int unsigned GSF_DEPTH      = 32;
  localparam int unsigned GSF_CNT_W      = 6;
  localparam int unsigned GSF_STAGE      = 8;
  localparam logic [7:0]  GSF_OFF_X_LO   = 8'h28;
  localparam logic [7:0]  GSF_OFF_X_HI   = 8'h29;
  localparam logic [7:0]  GSF_OFF_Y_LO   = 8'h2A;
  localparam logic [7:0]  GSF_OFF_Y_HI   = 8'h2B;
  localparam logic [7:0]  GSF_OFF_Z_LO   = 8'h2C;
  localparam logic [7:0]  GSF_OFF_Z_HI   = 8'h2D;
  localparam logic [7:0]  GSF_OFF_CTRL5  = 8'h24;
  localparam logic [7:0]  GSF_OFF_CTRL3  = 8'h22;
  localparam logic [7:0]  GSF_OFF_BCTRL  = 8'h2E;
  localparam logic [7:0]  GSF_OFF_STATUS = 8'h2F;
  localparam int unsigned GSF_EN_BIT     = 6;
  localparam int unsigned GSF_I2_WM_BIT  = 2;
  localparam int unsigned GSF_I2_OV_BIT  = 1;
  localparam int unsigned GSF_I2_EM_BIT  = 0;
  localparam logic [7:0]  GSF_BYPASS_STATUS = 8'h20;
  localparam logic [7:0]  GSF_RST_REG    = 8'h00;

  typedef enum logic [2:0] {
    GSF_BYPASS     = 3'h0,
    GSF_FILL_ONCE  = 3'h1,
    GSF_STREAM     = 3'h2,
    GSF_STREAM_FILL= 3'h3,
    GSF_BYP_STREAM = 3'h4
  } gsf_mode_type;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gsf_set_type;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gsf_reg_req_type;
endpackage : gsf_pkg

// *** gsf_sample_fifo.sv ***
// Purpose: gyro sample-set buffer with modes, watermark, overrun and pin
// Assumes: register strobes come from the serial interface on clk
// Notes:   control, mode and status registers share the register port
// What this block does
// - three channel stores advance as one set
// - 32 entries, 16 bits per channel
// - values stored unchanged, two's complement
// - set maps to 0x28..0x2D, low byte first
// - one set pushed per sample tick
// - fill lowest empty slot, then overwrite oldest
// - 33rd set drops oldest, shifts, appends last
// - outputs show oldest set when buffer active
// - five behaviours selectable
// - watermark, overrun and empty individually drive pin
// - three-bit field encodes the five behaviours
// - watermark flag when count exceeds level
// - overrun at 32 unread, cleared on read
// - bypass clears buffer, status forced 0x20
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// staging fifo
// ****************************************
module gsf_stage_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } gsf_stage_state_type;
  gsf_stage_state_type st;
  gsf_stage_state_type next_st;
  logic push;
  logic pop;

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + AW'(1);
    end
    if (pop)
      next_st.rp = st.rp + AW'(1);
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end
endmodule : gsf_stage_fifo

// ****************************************
// main buffer
// ****************************************
module gsf_sample_fifo
  import gsf_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // sample source
  input  wire logic                 sample_rate_tick,
  input  wire gsf_pkg::gsf_set_type live_set,
  input  wire logic                 trigger_event,
  // register port
  input  wire gsf_pkg::gsf_reg_req_type reg_req,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  // interrupt pin
  output logic                      secondary_interrupt_pin,
  // source ready, tied high, no back-pressure
  output logic                      sample_ready
);
  import gsf_pkg::*;

  typedef struct packed {
    logic [GSF_DEPTH-1:0][47:0] slots;
    logic [GSF_CNT_W-1:0]       count;
    logic                       overrun_flag;
    logic                       fifo_enable;
    logic [2:0]                 int_enables;
    logic [2:0]                 buffer_behaviour_field;
    logic [4:0]                 watermark_level;
    logic                       triggered;
    gsf_set_type                out_set;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       pin;
    logic [1:0]                 tick_sync;
    logic [1:0]                 trig_sync;
    logic                       tick_prev;
  } gsf_state_type;

  gsf_state_type st;
  gsf_state_type next_st;
  logic          tick_edge;
  logic          stg_valid;
  logic          stg_take;
  gsf_set_type   stg_set;
  logic          collecting;
  logic          full;
  logic          watermark_reached_flag;
  logic          empty_flag;
  logic [7:0]    buffer_status_register;
  gsf_set_type   head_set;
  logic          pop_req;
  logic [GSF_CNT_W-1:0] cnt_after_pop;

  // ****************************************
  // sample intake
  // ****************************************
  assign tick_edge = st.tick_sync[1] && !st.tick_prev;

  gsf_stage_fifo #(
    .WIDTH (48),
    .DEPTH (GSF_STAGE)
  ) u_stage (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .flush     (st.fifo_enable && st.buffer_behaviour_field == GSF_BYPASS),
    .in_valid  (tick_edge),
    .in_ready  (),
    .in_data   (live_set),
    .out_valid (stg_valid),
    .out_ready (stg_take),
    .out_data  (stg_set)
  );

  // ****************************************
  // flags and status
  // ****************************************
  assign full       = (st.count == GSF_CNT_W'(GSF_DEPTH));
  assign empty_flag = (st.count == '0);
  assign watermark_reached_flag = (st.count > {1'b0, st.watermark_level});
  assign head_set   = st.slots[0];
  assign pop_req    = reg_req.read && reg_req.addr == GSF_OFF_Z_HI && !empty_flag
                      && st.fifo_enable && st.buffer_behaviour_field != GSF_BYPASS;

  // collection gate per behaviour
  always_comb
  begin
    unique case (st.buffer_behaviour_field)
      GSF_FILL_ONCE:   collecting = !full;
      GSF_STREAM:      collecting = 1'b1;
      GSF_STREAM_FILL: collecting = !(st.triggered && full);
      GSF_BYP_STREAM:  collecting = st.triggered;
      default:         collecting = 1'b0;
    endcase
    collecting = collecting && st.fifo_enable;
  end
  // staged sets not collected are dropped, never held for later
  assign stg_take = 1'b1;
  assign sample_ready = 1'b1;

  always_comb
  begin
    if (st.buffer_behaviour_field == GSF_BYPASS)
      buffer_status_register = GSF_BYPASS_STATUS;
    else
      buffer_status_register = {watermark_reached_flag, st.overrun_flag, empty_flag,
                                (st.count == '0) ? 5'h00 : 5'(st.count - GSF_CNT_W'(1))};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    cnt_after_pop = st.count;
    next_st.tick_sync = {st.tick_sync[0], sample_rate_tick};
    next_st.trig_sync = {st.trig_sync[0], trigger_event};
    next_st.tick_prev = st.tick_sync[1];
    next_st.rvalid = reg_req.read;
    if (st.trig_sync[1] && st.buffer_behaviour_field != GSF_BYPASS)
      next_st.triggered = 1'b1;
    // pop shifts slots 1 to 31 down one place, the top slot keeps its value
    if (pop_req)
    begin
      for (int i = 0; i < GSF_DEPTH - 1; i++)
        next_st.slots[i] = st.slots[i+1];
      cnt_after_pop = st.count - GSF_CNT_W'(1);
      next_st.overrun_flag = 1'b0;
    end
    if (stg_valid && collecting)
    begin
      if (cnt_after_pop == GSF_CNT_W'(GSF_DEPTH))
      begin
        for (int i = 0; i < GSF_DEPTH - 1; i++)
          next_st.slots[i] = st.slots[i+1];
        next_st.slots[GSF_DEPTH-1] = stg_set;
      end
      else
      begin
        next_st.slots[cnt_after_pop[4:0]] = stg_set;
        cnt_after_pop = cnt_after_pop + GSF_CNT_W'(1);
      end
    end
    next_st.count = cnt_after_pop;
    if (cnt_after_pop == GSF_CNT_W'(GSF_DEPTH) && stg_valid && collecting)
      next_st.overrun_flag = 1'b1;
    // output registers follow the head when enabled outside bypass, the staged set when disabled, and hold in bypass
    if (st.fifo_enable && st.buffer_behaviour_field != GSF_BYPASS)
      next_st.out_set = (next_st.count != '0) ? next_st.slots[0] : st.out_set;
    else if (!st.fifo_enable && stg_valid)
      next_st.out_set = stg_set;
    // register writes
    if (reg_req.write)
    begin
      unique case (reg_req.addr)
        GSF_OFF_CTRL5: next_st.fifo_enable = reg_req.wdata[GSF_EN_BIT];
        GSF_OFF_CTRL3: next_st.int_enables = reg_req.wdata[2:0];
        GSF_OFF_BCTRL:
        begin
          next_st.buffer_behaviour_field = reg_req.wdata[7:5];
          next_st.watermark_level = reg_req.wdata[4:0];
          if (reg_req.wdata[7:5] == GSF_BYPASS)
          begin
            next_st.count = '0;
            next_st.overrun_flag = 1'b0;
            next_st.triggered = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // register reads
    unique case (reg_req.addr)
      GSF_OFF_X_LO:   next_st.rdata = st.out_set.x[7:0];
      GSF_OFF_X_HI:   next_st.rdata = st.out_set.x[15:8];
      GSF_OFF_Y_LO:   next_st.rdata = st.out_set.y[7:0];
      GSF_OFF_Y_HI:   next_st.rdata = st.out_set.y[15:8];
      GSF_OFF_Z_LO:   next_st.rdata = st.out_set.z[7:0];
      GSF_OFF_Z_HI:   next_st.rdata = st.out_set.z[15:8];
      GSF_OFF_CTRL5:  next_st.rdata = {1'b0, st.fifo_enable, 6'h00};
      GSF_OFF_CTRL3:  next_st.rdata = {5'h00, st.int_enables};
      GSF_OFF_BCTRL:  next_st.rdata = {st.buffer_behaviour_field, st.watermark_level};
      GSF_OFF_STATUS: next_st.rdata = buffer_status_register;
      default:        next_st.rdata = GSF_RST_REG;
    endcase
    if (!reg_req.read)
      next_st.rdata = st.rdata;
    next_st.pin = (st.int_enables[GSF_I2_WM_BIT] && buffer_status_register[7])
                  || (st.int_enables[GSF_I2_OV_BIT] && buffer_status_register[6])
                  || (st.int_enables[GSF_I2_EM_BIT] && buffer_status_register[5]);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign reg_rdata               = st.rdata;
  assign reg_rvalid              = st.rvalid;
  assign secondary_interrupt_pin = st.pin;
endmodule : gsf_sample_fifo
`default_nettype wire

// *** gsf_sva.sv ***
// Purpose: port checker of the gyro sample buffer
// Assumes: one clock; register writes land the next cycle
// Notes:   helper copies track the control registers
`timescale 1ns/10ps
`default_nettype none
module gsf_sva
  import gsf_pkg::*;
(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     ce,
  // sample source
  input wire logic                     sample_rate_tick,
  input wire gsf_pkg::gsf_set_type     live_set,
  input wire logic                     trigger_event,
  // register port and pin
  input wire gsf_pkg::gsf_reg_req_type reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     reg_rvalid,
  input wire logic                     secondary_interrupt_pin,
  input wire logic                     sample_ready
);
  // ****************
  // helper state
  // ****************
  logic [7:0] bctrl, ctl3, ctl5, last;
  logic [2:0] quiet;
  logic       rd, wr, byp, st;
  assign rd  = ce && reg_req.read;
  assign wr  = ce && reg_req.write;
  assign byp = quiet == 3'h7 && ctl5[GSF_EN_BIT] && bctrl[7:5] == 3'h0;
  assign st  = reg_rvalid && last == GSF_OFF_STATUS;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {bctrl, ctl3, ctl5, last} <= '0;
      quiet <= 3'h0;
    end
    else
    begin
      if (wr && reg_req.addr == GSF_OFF_BCTRL)
        bctrl <= reg_req.wdata;
      if (wr && reg_req.addr == GSF_OFF_CTRL3)
        ctl3 <= reg_req.wdata;
      if (wr && reg_req.addr == GSF_OFF_CTRL5)
        ctl5 <= reg_req.wdata;
      if (rd)
        last <= reg_req.addr;
      quiet <= wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
    end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_READ_ANSWER: assert property (rd |=> reg_rvalid)
    else $error("read not answered");
  AST_ANSWER_CAUSE: assert property (reg_rvalid && $past(ce) |-> $past(reg_req.read))
    else $error("answer without read");
  AST_UNMAPPED: assert property (reg_rvalid && last < 8'h20 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MODE_BACK: assert property (reg_rvalid && last == GSF_OFF_BCTRL |-> reg_rdata == bctrl)
    else $error("mode field readback");
  AST_EN_BACK: assert property (reg_rvalid && last == GSF_OFF_CTRL5 |-> reg_rdata[6] == ctl5[6])
    else $error("enable readback");
  AST_IE_BACK: assert property (reg_rvalid && last == GSF_OFF_CTRL3 |-> reg_rdata[2:0] == ctl3[2:0])
    else $error("pin enable readback");
  AST_BYP_STATUS: assert property (st && byp |-> reg_rdata == GSF_BYPASS_STATUS)
    else $error("bypass status");
  AST_OVERRUN_FLAG_FULL: assert property (st && reg_rdata[6] |-> reg_rdata[5:0] == 6'h1F)
    else $error("overrun without full count");
  AST_EMPTY_WM: assert property (st && reg_rdata[5] |-> reg_rdata[7:6] == 2'h0 && reg_rdata[4:0] == 5'h00)
    else $error("empty with count or flags");
  AST_PIN_BYP: assert property (byp |-> secondary_interrupt_pin == ctl3[GSF_I2_EM_BIT])
    else $error("pin in bypass");
  COV_POP: cover property (rd && reg_req.addr == GSF_OFF_Z_HI);
  COV_OVERRUN_FLAG: cover property (st && reg_rdata[6]);
  COV_PIN: cover property (secondary_interrupt_pin);
endmodule : gsf_sva
bind gsf_sample_fifo gsf_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .sample_rate_tick(sample_rate_tick),
  .live_set(live_set), .trigger_event(trigger_event), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .secondary_interrupt_pin(secondary_interrupt_pin), .sample_ready(sample_ready));
`default_nettype wire

// *** gsf_host.sv ***
// Purpose: host model on the register port
// Assumes: requests change at the falling edge
// Notes:   released address shows its inverse
`timescale 1ns/10ps
`default_nettype none
module gsf_host
  import gsf_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // register port
  output var gsf_pkg::gsf_reg_req_type reg_req,
  input  wire logic [7:0]              reg_rdata,
  input  wire logic                    reg_rvalid
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = {1'b0, 1'b1, a, d};
    @(negedge clk);
    reg_req = {1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    reg_req = {1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    reg_req = {1'b0, 1'b0, ~a, 8'hFF};
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
      @(negedge clk);
    d = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : gsf_host
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the gyro sample buffer
// Assumes: host model drives the register port
// Notes:   every byte of a set carries its index
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gsf_pkg::*;
  logic            clk, rst_n, tick, trig, rvalid, pin, sready, ce;
  gsf_set_type     live;
  gsf_reg_req_type req;
  logic [7:0]      rdata, v;
  int              bad_count, checks;
  gsf_sample_fifo DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .sample_rate_tick(tick), .live_set(live),
    .trigger_event(trig), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .secondary_interrupt_pin(pin), .sample_ready(sready));
  gsf_host host (.clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  function automatic gsf_set_type mk(input int n);
    logic [7:0] b;
    b = 8'(n);
    return {8'h80 + b, b, 8'hC0 + b, 8'h40 + b, 8'h60 + b, 8'h20 + b};
  endfunction : mk
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    host.rd(a, v);
    cmp(what, exp, v);
  endtask : rchk
  task automatic push(input int n);
    @(negedge clk);
    live = mk(n);
    tick = 1'b1;
    repeat (4) @(negedge clk);
    tick = 1'b0;
    repeat (8) @(negedge clk);
    live = ~live;
  endtask : push
  task automatic fill(input int a, input int b);
    for (int i = a; i <= b; i++)
      push(i);
  endtask : fill
  task automatic mode(input gsf_mode_type m);
    host.wr(GSF_OFF_BCTRL, {m, 5'h03});
    repeat (8) @(negedge clk);
  endtask : mode
  task automatic head(input int n);
    logic [47:0] w;
    w = mk(n);
    for (int i = 0; i < 6; i++)
      rchk(GSF_OFF_X_LO + 8'(i), w[8*(4 - 2*(i/2) + i%2) +: 8], "output byte");
  endtask : head
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    {rst_n, tick, trig, bad_count, checks} = '0;
    live = mk(0);
    ce = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    host.wr(GSF_OFF_CTRL5, 8'h40);
    host.wr(GSF_OFF_CTRL3, 8'h02);
    mode(GSF_BYPASS);
    rchk(8'h10, 8'h00, "unmapped");
    rchk(GSF_OFF_STATUS, GSF_BYPASS_STATUS, "bypass status");
    cmp("pin", 8'h00, {7'h00, pin});
    $display("test setup done");
    mode(GSF_FILL_ONCE);
    rchk(GSF_OFF_BCTRL, {GSF_FILL_ONCE, 5'h03}, "mode field");
    fill(0, 2);
    rchk(GSF_OFF_STATUS, 8'h02, "status at level");
    push(3);
    rchk(GSF_OFF_STATUS, 8'h83, "status above level");
    fill(4, 32);
    rchk(GSF_OFF_STATUS, 8'hDF, "status full");
    cmp("pin", 8'h01, {7'h00, pin});
    head(0);
    rchk(GSF_OFF_STATUS, 8'h9E, "status after pop");
    cmp("pin", 8'h00, {7'h00, pin});
    head(1);
    $display("test fill once done");
    mode(GSF_BYPASS);
    rchk(GSF_OFF_STATUS, GSF_BYPASS_STATUS, "cleared status");
    mode(GSF_STREAM);
    fill(0, 33);
    rchk(GSF_OFF_STATUS, 8'hDF, "stream status");
    head(2);
    $display("test stream done");
    mode(GSF_BYPASS);
    mode(GSF_STREAM_FILL);
    fill(0, 33);
    trig = 1'b1;
    repeat (4) @(negedge clk);
    push(40);
    head(2);
    $display("test stream then fill done");
    trig = 1'b0;
    mode(GSF_BYPASS);
    mode(GSF_BYP_STREAM);
    push(50);
    trig = 1'b1;
    repeat (4) @(negedge clk);
    fill(51, 52);
    rchk(GSF_OFF_STATUS, 8'h01, "after trigger");
    ce = 1'b0;
    push(60);
    ce = 1'b1;
    rchk(GSF_OFF_STATUS, 8'h01, "frozen by enable");
    head(51);
    $display("test bypass then stream done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
